//--- fdm_cfg.svh
// Constants for the flash disk DMA request control block
`ifndef FDM_CFG_SVH
`define FDM_CFG_SVH

// ----------------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------------
`define FDM_SETUP_IDX   16'h1078
`define FDM_DROP_IDX    16'h107A
`define FDM_STATUS_IDX  16'h1080
`define FDM_ADDR_W      20

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define FDM_CNT_W       7
`define FDM_RSV_SETUP_W 5
`define FDM_POL_BIT     12
`define FDM_MODE_BIT    13
`define FDM_PAUSE_BIT   14
`define FDM_EN_BIT      15
`define FDM_DROP_W      10
`define FDM_SRC_W       6
`define FDM_DATA_W      16
`define FDM_FIFO_DEPTH  16

// ----------------------------------------------------------------------
// Interrupt source codes and bus answers
// ----------------------------------------------------------------------
`define FDM_SRC_ECC     6'h03
`define FDM_SRC_DONE    6'h05
`define FDM_RESP_OKAY   2'h0
`define FDM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FDM_PULSE_NS    250
`define FDM_CLK_NS      10
`define FDM_PULSE_CYC   ((`FDM_PULSE_NS + `FDM_CLK_NS - 1) / `FDM_CLK_NS)
`define FDM_PCNT_W      8

`endif

//--- fdm_dma_ctrl.sv
// DMA request control: registers, request line, sector count, pause
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fdm_cfg.svh"

module fdm_dma_ctrl (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`FDM_ADDR_W-1:0] awaddr,
   input  wire logic [2:0]             awprot,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`FDM_ADDR_W-1:0] araddr,
   input  wire logic [2:0]             arprot,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic                   sector_ecc_done,
   input  wire logic                   ecc_error,
   input  wire logic                   bus_cycle_start,
   input  wire logic [`FDM_DROP_W-1:0] flash_byte_tally,
   input  wire logic [`FDM_DATA_W-1:0] buf_data,
   input  wire logic                   buf_valid,
   output logic                        buf_ready,
   output logic [`FDM_DATA_W-1:0]      host_data,
   output logic                        host_valid,
   input  wire logic                   host_ready,
   output logic                        transfer_request_line
);

   // ----------------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------------
   localparam int PULSE_CYC = `FDM_PULSE_CYC;

   fdm_pkg::fdm_top_s s;
   fdm_pkg::fdm_top_s next_s;
   fdm_fifo_if #(.W(`FDM_DATA_W)) fq ();

   logic        wr_fire;
   logic        wr_setup;
   logic        active;
   logic        flow_ok;
   logic        req_on;
   logic [31:0] rd_word;
   logic        rd_hit;

   fdm_fifo #(
      .W     (`FDM_DATA_W),
      .DEPTH (`FDM_FIFO_DEPTH)
   ) u_fifo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .f       (fq.fifo)
   );

   assign fq.in_data  = buf_data;
   assign fq.in_valid = buf_valid;
   assign buf_ready   = fq.in_ready;

   // Data leaves the FIFO only while enabled and not paused; a word already in the host stage stays offered
   assign flow_ok      = s.core.en && !s.core.pause;
   assign fq.out_ready = flow_ok && (!s.core.host_valid || host_ready);
   assign active       = (s.core.state == fdm_pkg::FDM_ASSERT) || (s.core.state == fdm_pkg::FDM_WAIT);

   // ----------------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (araddr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_SETUP_IDX}) begin
         rd_word = {16'h0, s.core.en, s.core.pause, s.core.pulse_mode, s.core.pol,
                    {`FDM_RSV_SETUP_W{1'b0}}, s.core.cnt};
      end else if (araddr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_DROP_IDX}) begin
         rd_word = {22'h0, s.core.drop};
      end else if (araddr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_STATUS_IDX}) begin
         rd_word = {22'h0, s.core.state, 2'h0, s.core.src};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s   = s;
      wr_fire  = 1'b0;
      wr_setup = 1'b0;
      req_on   = 1'b0;

      // Write channel: address and data taken in either order
      if (awvalid && s.axi.awready) begin
         next_s.axi.aw_have = 1'b1;
         next_s.axi.aw_addr = awaddr;
         next_s.axi.awready = 1'b0;
      end
      if (wvalid && s.axi.wready) begin
         next_s.axi.w_have = 1'b1;
         next_s.axi.w_data = wdata;
         next_s.axi.w_strb = wstrb;
         next_s.axi.wready = 1'b0;
      end
      if (s.axi.aw_have && s.axi.w_have && !s.axi.bvalid) begin
         wr_fire            = 1'b1;
         next_s.axi.aw_have = 1'b0;
         next_s.axi.w_have  = 1'b0;
         next_s.axi.bvalid  = 1'b1;
         next_s.axi.bresp   = `FDM_RESP_SLVERR;
      end
      if (s.axi.bvalid && bready) begin
         next_s.axi.bvalid  = 1'b0;
         next_s.axi.awready = 1'b1;
         next_s.axi.wready  = 1'b1;
      end

      // Register writes; reserved bits are simply not stored
      if (wr_fire) begin
         if (s.axi.aw_addr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_SETUP_IDX}) begin
            wr_setup          = 1'b1;
            next_s.axi.bresp  = `FDM_RESP_OKAY;
            if (s.axi.w_strb[0]) begin
               next_s.core.cnt = s.axi.w_data[`FDM_CNT_W-1:0];
            end
            if (s.axi.w_strb[1]) begin
               next_s.core.pol        = s.axi.w_data[`FDM_POL_BIT];
               next_s.core.pulse_mode = s.axi.w_data[`FDM_MODE_BIT];
               // Software may only clear pause; writing one keeps it
               next_s.core.pause      = s.core.pause && s.axi.w_data[`FDM_PAUSE_BIT];
               next_s.core.en         = s.axi.w_data[`FDM_EN_BIT];
            end
         end else if (s.axi.aw_addr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_DROP_IDX}) begin
            next_s.axi.bresp = `FDM_RESP_OKAY;
            if (s.axi.w_strb[0]) begin
               next_s.core.drop[7:0] = s.axi.w_data[7:0];
            end
            if (s.axi.w_strb[1]) begin
               next_s.core.drop[`FDM_DROP_W-1:8] = s.axi.w_data[`FDM_DROP_W-1:8];
            end
         end else if (s.axi.aw_addr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_STATUS_IDX}) begin
            next_s.axi.bresp = `FDM_RESP_OKAY;
         end
      end

      // Read channel
      if (arvalid && s.axi.arready) begin
         next_s.axi.arready = 1'b0;
         next_s.axi.rvalid  = 1'b1;
         next_s.axi.rdata   = rd_word;
         next_s.axi.rresp   = rd_hit ? `FDM_RESP_OKAY : `FDM_RESP_SLVERR;
      end
      if (s.axi.rvalid && rready) begin
         next_s.axi.rvalid  = 1'b0;
         next_s.axi.arready = 1'b1;
      end

      // Transfer sequencing
      if (!next_s.core.en) begin
         next_s.core.state = fdm_pkg::FDM_IDLE;
      end else begin
         unique case (s.core.state)
            fdm_pkg::FDM_IDLE: begin
               if (!next_s.core.pause) begin
                  next_s.core.state     = fdm_pkg::FDM_ASSERT;
                  next_s.core.pulse_cnt = '0;
               end
            end
            fdm_pkg::FDM_ASSERT: begin
               if (s.core.pulse_mode) begin
                  next_s.core.pulse_cnt = s.core.pulse_cnt + 1'b1;
                  if (s.core.pulse_cnt == `FDM_PCNT_W'(PULSE_CYC - 1)) begin
                     next_s.core.state = fdm_pkg::FDM_WAIT;
                  end
               end else if (bus_cycle_start && (flash_byte_tally == s.core.drop)) begin
                  next_s.core.state = fdm_pkg::FDM_WAIT;
               end
            end
            fdm_pkg::FDM_WAIT: begin
               next_s.core.state = fdm_pkg::FDM_WAIT;
            end
            fdm_pkg::FDM_PAUSED: begin
               // Clearing pause re-raises the request for the same sector
               if (!next_s.core.pause) begin
                  next_s.core.state     = fdm_pkg::FDM_ASSERT;
                  next_s.core.pulse_cnt = '0;
               end
            end
         endcase

         if (active && ecc_error) begin
            // Error wins over a same-cycle sector end; count is left alone
            next_s.core.pause = 1'b1;
            next_s.core.src   = `FDM_SRC_ECC;
            next_s.core.state = fdm_pkg::FDM_PAUSED;
         end else if (active && sector_ecc_done) begin
            if (s.core.cnt == '0) begin
               next_s.core.en    = 1'b0;
               next_s.core.src   = `FDM_SRC_DONE;
               next_s.core.state = fdm_pkg::FDM_IDLE;
            end else begin
               next_s.core.cnt       = s.core.cnt - 1'b1;
               next_s.core.state     = fdm_pkg::FDM_ASSERT;
               next_s.core.pulse_cnt = '0;
            end
         end
      end

      // Request line level from polarity
      req_on               = (next_s.core.state == fdm_pkg::FDM_ASSERT) && next_s.core.en && !next_s.core.pause;
      next_s.core.req_line = next_s.core.pol ? req_on : !req_on;

      // Output stage toward the host
      if (fq.out_ready) begin
         next_s.core.host_valid = fq.out_valid;
         next_s.core.host_data  = fq.out_data;
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s                 <= '0;
         s.axi.awready     <= 1'b1;
         s.axi.wready      <= 1'b1;
         s.axi.arready     <= 1'b1;
         s.core.req_line   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign awready               = s.axi.awready;
   assign wready                = s.axi.wready;
   assign bvalid                = s.axi.bvalid;
   assign bresp                 = s.axi.bresp;
   assign arready               = s.axi.arready;
   assign rvalid                = s.axi.rvalid;
   assign rresp                 = s.axi.rresp;
   assign rdata                 = s.axi.rdata;
   assign host_valid            = s.core.host_valid;
   assign host_data             = s.core.host_data;
   assign transfer_request_line = s.core.req_line;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_count_decrement: assert property (
      active && sector_ecc_done && !ecc_error && (s.core.cnt != '0) && !wr_setup && s.core.en
      |=> (s.core.cnt == $past(s.core.cnt) - 1'b1) && (s.core.state == fdm_pkg::FDM_ASSERT))
      else $error("sector count did not step down");

   chk_last_sector: assert property (
      active && sector_ecc_done && !ecc_error && (s.core.cnt == '0) && !wr_setup
      |=> !s.core.en && (s.core.src == `FDM_SRC_DONE) && (s.core.state == fdm_pkg::FDM_IDLE))
      else $error("zero count did not end after one more sector");

   chk_count_hold_err: assert property (
      active && ecc_error && !wr_setup && s.core.en
      |=> (s.core.cnt == $past(s.core.cnt)) && s.core.pause && (s.core.src == `FDM_SRC_ECC))
      else $error("ecc error changed count or missed pause");

   chk_pause_stall: assert property (
      s.core.pause |-> !fq.out_ready && (s.core.state != fdm_pkg::FDM_ASSERT))
      else $error("transfer moved while paused");

   chk_idle_high: assert property (
      !s.core.pol |-> (transfer_request_line == (s.core.state != fdm_pkg::FDM_ASSERT)))
      else $error("active-low request level wrong");

   chk_idle_low: assert property (
      s.core.pol |-> (transfer_request_line == (s.core.state == fdm_pkg::FDM_ASSERT)))
      else $error("active-high request level wrong");

   chk_pulse_width: assert property (
      $rose(s.core.state == fdm_pkg::FDM_ASSERT) && s.core.pulse_mode && !ecc_error && !sector_ecc_done
      |-> (s.core.pulse_cnt == '0))
      else $error("pulse did not start from zero");

   chk_pulse_end: assert property (
      (s.core.state == fdm_pkg::FDM_ASSERT) && s.core.pulse_mode && !ecc_error && !sector_ecc_done
      && !wr_fire && (s.core.pulse_cnt == `FDM_PCNT_W'(PULSE_CYC - 1))
      |=> (s.core.state == fdm_pkg::FDM_WAIT) && (transfer_request_line == !s.core.pol))
      else $error("pulse length wrong");

   chk_level_drop: assert property (
      (s.core.state == fdm_pkg::FDM_ASSERT) && !s.core.pulse_mode && bus_cycle_start && !wr_fire
      && (flash_byte_tally == s.core.drop) && !ecc_error && !sector_ecc_done
      |=> (s.core.state == fdm_pkg::FDM_WAIT))
      else $error("level request not dropped at tally match");

   chk_disabled_quiet: assert property (
      !s.core.en |-> (s.core.state == fdm_pkg::FDM_IDLE) && (transfer_request_line == !s.core.pol))
      else $error("request raised while disabled");

   chk_reserved_zero: assert property (
      arvalid && s.axi.arready && (araddr[`FDM_ADDR_W-1:2] == {2'h0, `FDM_SETUP_IDX})
      |=> (s.axi.rdata[`FDM_POL_BIT-1:`FDM_CNT_W] == '0) && (s.axi.rdata[31:16] == '0))
      else $error("reserved bits read nonzero");

   chk_reset_clear: assert property (
      !$past(aresetn) |-> (s.core.cnt == '0) && !s.core.en && !s.core.pause && transfer_request_line)
      else $error("registers not cleared by reset");

   cov_pulse_done: cover property (s.core.pulse_mode && (s.core.state == fdm_pkg::FDM_ASSERT)
      ##1 (s.core.state == fdm_pkg::FDM_WAIT));
   cov_level_drop: cover property (!s.core.pulse_mode && (s.core.state == fdm_pkg::FDM_ASSERT)
      ##1 (s.core.state == fdm_pkg::FDM_WAIT));
   cov_pause_resume: cover property ((s.core.state == fdm_pkg::FDM_PAUSED)
      ##1 (s.core.state == fdm_pkg::FDM_ASSERT));
   cov_complete: cover property (s.core.en ##1 (!s.core.en && (s.core.src == `FDM_SRC_DONE)));

endmodule

`default_nettype wire

//--- fdm_fifo.sv
// Sector data FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module fdm_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   fdm_fifo_if.fifo f
);
   // Pointers wrap naturally, so DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    in_rdy;
   } fdm_fifo_s;

   fdm_fifo_s s;
   fdm_fifo_s next_s;
   logic      push;
   logic      pop;

   always_comb begin
      next_s = s;
      push   = f.in_valid && s.in_rdy;
      pop    = f.out_ready && (s.cnt != '0);
      if (push) begin
         next_s.mem[s.wp] = f.in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt    = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Registered ready keeps the filling side free of a long path
      next_s.in_rdy = (next_s.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s        <= '0;
         s.in_rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign f.in_ready  = s.in_rdy;
   assign f.out_valid = (s.cnt != '0);
   assign f.out_data  = s.mem[s.rp];
endmodule

`default_nettype wire

//--- fdm_fifo_if.sv
// Stream carrier between the DMA control core and its sector FIFO
`timescale 1ns/1ps
`default_nettype none

interface fdm_fifo_if #(parameter int W = 16);
   logic [W-1:0] in_data;
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] out_data;
   logic         out_valid;
   logic         out_ready;

   modport fifo (input in_data, input in_valid, output in_ready,
                 output out_data, output out_valid, input out_ready);
   modport user (output in_data, output in_valid, input in_ready,
                 input out_data, input out_valid, output out_ready);
endinterface

`default_nettype wire

//--- fdm_host_model.sv
// Host DMA controller model: runs bus cycles while the request is asserted
`timescale 1ns/1ps
`default_nettype none
module fdm_host_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pol,
   input  wire logic stall,
   input  wire logic transfer_request_line,
   output logic      host_ready,
   output logic      bus_cycle_start
);
   logic [1:0] ph;
   logic       act;
   assign act = (transfer_request_line == pol);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph <= 2'h0;
         host_ready <= 1'b0;
         bus_cycle_start <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         // A cycle every fourth clock, only while requested
         bus_cycle_start <= act && (ph == 2'h3);
         host_ready <= !stall && ph[0];
      end
   end
endmodule
`default_nettype wire

//--- fdm_pkg.sv
// Types of the flash disk DMA request control block
`include "fdm_cfg.svh"

package fdm_pkg;

   typedef enum logic [1:0] {
      FDM_IDLE   = 2'b00,
      FDM_ASSERT = 2'b01,
      FDM_WAIT   = 2'b10,
      FDM_PAUSED = 2'b11
   } fdm_state_e;

   typedef struct packed {
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic                   aw_have;
      logic                   w_have;
      logic [`FDM_ADDR_W-1:0] aw_addr;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
   } fdm_axi_s;

   typedef struct packed {
      fdm_state_e             state;
      logic [`FDM_CNT_W-1:0]  cnt;
      logic                   pol;
      logic                   pulse_mode;
      logic                   pause;
      logic                   en;
      logic [`FDM_DROP_W-1:0] drop;
      logic [`FDM_SRC_W-1:0]  src;
      logic [`FDM_PCNT_W-1:0] pulse_cnt;
      logic                   req_line;
      logic                   host_valid;
      logic [`FDM_DATA_W-1:0] host_data;
   } fdm_core_s;

   typedef struct packed {
      fdm_axi_s  axi;
      fdm_core_s core;
   } fdm_top_s;

endpackage

//--- testbench.sv
// Self-checking bench for the DMA request control block
`timescale 1ns/1ps
`default_nettype none
`include "fdm_cfg.svh"
module testbench;
   localparam logic [19:0] A_SET = `FDM_SETUP_IDX * 4;
   localparam logic [19:0] A_DRP = `FDM_DROP_IDX * 4;
   localparam logic [19:0] A_STA = `FDM_STATUS_IDX * 4;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [2:0]  awprot, arprot;
   logic [1:0]  bresp, rresp;
   logic        sector_ecc_done, ecc_error, bus_cycle_start, buf_valid, buf_ready, host_valid, host_ready;
   logic [9:0]  flash_byte_tally;
   logic [15:0] buf_data, host_data;
   logic        transfer_request_line, pol, stall;
   int          err_total, num_checks, seed, n;
   logic [33:0] rd_q[$];
   logic [15:0] dat_q[$];

   fdm_dma_ctrl fdm_dma_ctrl_i (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .sector_ecc_done, .ecc_error, .bus_cycle_start, .flash_byte_tally, .buf_data, .buf_valid, .buf_ready,
      .host_data, .host_valid, .host_ready, .transfer_request_line);
   fdm_host_model fdm_host_model_i (.aclk, .aresetn, .pol, .stall, .transfer_request_line, .host_ready,
      .bus_cycle_start);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // Starts on a fresh edge so no signal is driven twice in one step
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [19:0] a, input logic [33:0] e);
      @(posedge aclk);
      rd_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask

   task automatic pulse_in(input logic err);
      @(posedge aclk);
      ecc_error <= err;
      sector_ecc_done <= !err;
      @(posedge aclk);
      ecc_error <= 1'b0;
      sector_ecc_done <= 1'b0;
   endtask

   task automatic wait_line(input logic v);
      int i;
      i = 0;
      while (transfer_request_line !== v && i < 300) begin
         @(posedge aclk);
         i++;
      end
      chk({33'h0, transfer_request_line}, {33'h0, v});
   endtask

   // ----------------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
      if (host_valid && host_ready) chk({18'h0, host_data}, {18'h0, dat_q.pop_front()});
      if (bvalid && bready) chk({32'h0, bresp}, {32'h0, `FDM_RESP_OKAY});
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      stop_test;
   end

   initial begin
      seed = 32'hc6913043;
      {err_total, num_checks} = 0;
      {aresetn, awaddr, awprot, awvalid, wdata, wvalid, bready, araddr, arprot, arvalid, rready} = 0;
      {sector_ecc_done, ecc_error, flash_byte_tally, buf_data, buf_valid, pol, stall} = 0;
      wstrb = 4'hF;
      cyc(6);
      aresetn <= 1'b1;
      cyc(2);
      chk({33'h0, transfer_request_line}, 34'h1);
      rd(A_SET, 34'h0);
      rd(A_DRP, 34'h0);
      rd(20'h00100, {`FDM_RESP_SLVERR, 32'h0});
      wr(A_SET, 16'h4F80);
      rd(A_SET, 34'h0);
      wr(A_DRP, 16'hFFFF);
      rd(A_DRP, 34'h3FF);
      wr(A_SET, 16'h1000);
      pol <= 1'b1;
      cyc(3);
      chk({33'h0, transfer_request_line}, 34'h0);
      // Pulse mode with high polarity, two sectors
      wr(A_SET, 16'hB001);
      wait_line(1'b1);
      n = 0;
      while (transfer_request_line === 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      chk(34'(n), 34'(`FDM_PULSE_CYC));
      cyc(5);
      pulse_in(1'b0);
      rd(A_SET, 34'hB000);
      cyc(30);
      pulse_in(1'b0);
      rd(A_SET, 34'h3000);
      rd(A_STA, 34'h5);
      chk({33'h0, transfer_request_line}, 34'h0);
      // Level mode, low polarity, drop point for last 16-bit word
      wr(A_DRP, 16'd2 + 16'd16 + 16'd2);
      pol <= 1'b0;
      stall <= 1'b1;
      wr(A_SET, 16'h8002);
      cyc(10);
      chk({33'h0, transfer_request_line}, 34'h0);
      buf_valid <= 1'b1;
      buf_data <= 16'($random(seed));
      n = 0;
      do begin
         @(posedge aclk);
         if (buf_ready) begin
            dat_q.push_back(buf_data);
            n++;
            buf_data <= 16'($random(seed));
         end
      end while (buf_ready && n < 20);
      buf_valid <= 1'b0;
      // FIFO full plus the one word parked in the host stage
      chk(34'(n), 34'(`FDM_FIFO_DEPTH + 1));
      stall <= 1'b0;
      n = 0;
      while (dat_q.size() > 0 && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk(34'(dat_q.size()), 34'h0);
      flash_byte_tally <= 10'd20;
      wait_line(1'b1);
      pulse_in(1'b0);
      wait_line(1'b0);
      rd(A_SET, 34'h8001);
      pulse_in(1'b1);
      cyc(3);
      chk({33'h0, transfer_request_line}, 34'h1);
      rd(A_SET, 34'hC001);
      rd(A_STA, 34'h303);
      wr(A_SET, 16'h8001);
      wait_line(1'b0);
      wr(A_SET, 16'h0000);
      cyc(2);
      chk({33'h0, transfer_request_line}, 34'h1);
      stop_test;
   end
endmodule
`default_nettype wire
